// File: rtl/rsc_params.svh
// Functional notes
// - Low external reset pin forces reset
// - Hold reset twelve cycles after pin release
// - Pin flag set on leaving pin reset
// - Lost clock one-shot resets after 100 ms
// - Lost clock flag marks only lost-clock reset
// - Lost clock detector runs only when enabled
// - Internal resets never drive the reset pin
// - Writing enable bit arms comparator reset
// - Armed comparator low forces reset
// - Comparator bit reads one after comparator reset
// - Watchdog overflow counted on i_clock forces reset
// - Every reset re-enables watchdog, longest interval
// - Locked watchdog ignores disable until reset
// - Watchdog counter is 21 bits, counts i_clock
// - Writing A5 enables and restarts watchdog
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define RSC_ADDR_W 8
`define RSC_ADDR_CAUSE 8'h00
`define RSC_ADDR_OSC 8'h04
`define RSC_ADDR_WDOG 8'h08

// ****************************************
// Field positions
// ****************************************
`define RSC_BIT_PIN 0
`define RSC_BIT_LOST 2
`define RSC_BIT_WDOG 3
`define RSC_BIT_CMP_EN 5
`define RSC_BIT_LOST_EN 7
`define RSC_BIT_WDOG_EN 4
`define RSC_BIT_WDOG_LOCK 5
`define RSC_BIT_WDOG_CMD 7

// ****************************************
// Watchdog commands and layout
// ****************************************
`define RSC_WDOG_KICK 8'hA5
`define RSC_WDOG_DISABLE 8'hDE
`define RSC_WDOG_LOCK 8'hFF
`define RSC_WDOG_W 21
`define RSC_WDOG_FULL 21'h1FFFFF
`define RSC_WDOG_SEL_MAX 3'h7

// ****************************************
// Timing
// ****************************************
`define RSC_CLK_KHZ 50000
`define RSC_HOLD_CYCLES 4'hC
`define RSC_LOST_CLOCK_MS 100
`define RSC_LOST_CLOCK_CYCLES (`RSC_LOST_CLOCK_MS * `RSC_CLK_KHZ)

// ****************************************
// Bus answers
// ****************************************
`define RSC_RESP_OKAY 2'h0
`define RSC_RESP_SLVERR 2'h2

`endif

// File: rtl/rsc_pkg.sv
`include "rsc_params.svh"

package rsc_pkg;

	// Sequencer phase
	typedef enum logic {ST_RUN, ST_HOLD} rsc_state_e;

	// Latched reset cause
	typedef enum logic [2:0] {CAUSE_NONE, CAUSE_PIN, CAUSE_LOST, CAUSE_CMP, CAUSE_WDOG} rsc_cause_e;

	// Whole block state
	typedef struct packed {
		logic [2:0] ext_sync; // Pin synchroniser chain
		logic ext_lvl; // Filtered pin level
		logic [2:0] cmp_sync; // Comparator synchroniser chain
		logic cmp_lvl; // Filtered comparator level
		logic [2:0] clk_sync; // System clock sample chain
		logic clk_lvl; // Filtered system clock level
		rsc_state_e state; // Run or holding reset
		rsc_cause_e cause; // Cause of current reset
		logic [3:0] hold_cnt; // Release countdown
		logic pin_flag; // Last reset came from pin
		logic lost_flag; // Last reset from lost clock
		logic wdog_flag; // Last reset from watchdog
		logic cmp_en; // Comparator reset armed / source
		logic lost_en; // Lost clock detector enable
		logic [31:0] lost_cnt; // One-shot timer
		logic wdog_en; // Watchdog running
		logic wdog_lock; // Watchdog locked on
		logic [2:0] wdog_sel; // Interval select
		logic [`RSC_WDOG_W-1:0] wdog_cnt; // Watchdog counter
		logic aw_have; // Write address held
		logic [`RSC_ADDR_W-1:0] aw_addr; // Held write address
		logic w_have; // Write data held
		logic [7:0] w_data; // Held write byte
		logic w_strb0; // Low lane enabled
		logic bvalid; // Write answer pending
		logic [1:0] bresp; // Write answer code
		logic rvalid; // Read answer pending
		logic [7:0] rdata; // Read byte
		logic [1:0] rresp; // Read answer code
	} rsc_state_s;

endpackage

// File: rtl/rsc_reset_source.sv
`timescale 1ns/100ps
`default_nettype none
`include "rsc_params.svh"

module rsc_reset_source #(
	parameter int unsigned LOST_CLOCK_CYCLES = `RSC_LOST_CLOCK_CYCLES
) (
	// Clock and power-on reset
	input wire logic i_clock,
	input wire logic i_rst,
	// Reset sources from outside
	input wire logic i_ext_reset_n,
	input wire logic i_system_clock,
	input wire logic i_comparator_out,
	// Reset to the core
	output logic o_sys_reset,
	// AXI4-Lite write address
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [`RSC_ADDR_W-1:0] i_awaddr,
	// AXI4-Lite write data
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	// AXI4-Lite write response
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	// AXI4-Lite read address
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [`RSC_ADDR_W-1:0] i_araddr,
	// AXI4-Lite read data
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp
);

	// ****************************************
	// Helpers
	// ****************************************

	// Terminal count for an interval select; 7 uses all 21 bits
	function automatic logic [`RSC_WDOG_W-1:0] wdog_limit(input logic [2:0] sel);
		wdog_limit = `RSC_WDOG_FULL >> (`RSC_WDOG_SEL_MAX - sel);
	endfunction

	// Register read decode
	function automatic logic [7:0] read_reg(input rsc_pkg::rsc_state_s s,
		input logic [`RSC_ADDR_W-1:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			`RSC_ADDR_CAUSE:
			begin
				v[`RSC_BIT_PIN] = s.pin_flag;
				v[`RSC_BIT_LOST] = s.lost_flag;
				v[`RSC_BIT_WDOG] = s.wdog_flag;
				v[`RSC_BIT_CMP_EN] = s.cmp_en;
			end
			`RSC_ADDR_OSC:
			begin
				v[`RSC_BIT_LOST_EN] = s.lost_en;
			end
			`RSC_ADDR_WDOG:
			begin
				v[2:0] = s.wdog_sel;
				v[`RSC_BIT_WDOG_EN] = s.wdog_en;
				v[`RSC_BIT_WDOG_LOCK] = s.wdog_lock;
			end
			default:
			begin
				v = 8'h00;
			end
		endcase
		read_reg = v;
	endfunction

	// Address hits a register
	function automatic logic mapped(input logic [`RSC_ADDR_W-1:0] a);
		mapped = (a == `RSC_ADDR_CAUSE) || (a == `RSC_ADDR_OSC) || (a == `RSC_ADDR_WDOG);
	endfunction

	// ****************************************
	// State
	// ****************************************

	rsc_pkg::rsc_state_s state_q; // Registered state
	rsc_pkg::rsc_state_s state_d; // Next state
	logic pin_hit; // Pin held low
	logic cmp_hit; // Armed comparator low
	logic lost_fire; // One-shot timed out
	logic wdog_fire; // Watchdog overflow
	logic clk_edge; // Filtered system clock toggled

	// Power-on value: held in reset with no cause, so all flags read zero
	localparam rsc_pkg::rsc_state_s RESET_STATE = '{
		ext_sync: 3'h7, ext_lvl: 1'b1,
		cmp_sync: 3'h7, cmp_lvl: 1'b1,
		clk_sync: 3'h0, clk_lvl: 1'b0,
		state: rsc_pkg::ST_HOLD, cause: rsc_pkg::CAUSE_NONE,
		hold_cnt: `RSC_HOLD_CYCLES,
		pin_flag: 1'b0, lost_flag: 1'b0, wdog_flag: 1'b0, cmp_en: 1'b0,
		lost_en: 1'b0, lost_cnt: 32'h0,
		wdog_en: 1'b1, wdog_lock: 1'b0, wdog_sel: `RSC_WDOG_SEL_MAX,
		wdog_cnt: '0,
		aw_have: 1'b0, aw_addr: '0, w_have: 1'b0, w_data: 8'h00,
		w_strb0: 1'b0, bvalid: 1'b0, bresp: `RSC_RESP_OKAY,
		rvalid: 1'b0, rdata: 8'h00, rresp: `RSC_RESP_OKAY
	};

	// ****************************************
	// Next-state logic
	// ****************************************

	// Sources, bus and sequencer in one pass; later writes win
	always_comb
	begin
		state_d = state_q;

		// Three-flop chains; level moves only when stages two and three agree
		state_d.ext_sync = {state_q.ext_sync[1:0], i_ext_reset_n};
		state_d.cmp_sync = {state_q.cmp_sync[1:0], i_comparator_out};
		state_d.clk_sync = {state_q.clk_sync[1:0], i_system_clock};
		if (state_q.ext_sync[1] == state_q.ext_sync[2])
		begin
			state_d.ext_lvl = state_q.ext_sync[2];
		end
		if (state_q.cmp_sync[1] == state_q.cmp_sync[2])
		begin
			state_d.cmp_lvl = state_q.cmp_sync[2];
		end
		if (state_q.clk_sync[1] == state_q.clk_sync[2])
		begin
			state_d.clk_lvl = state_q.clk_sync[2];
		end
		clk_edge = (state_q.clk_sync[1] == state_q.clk_sync[2])
			&& (state_q.clk_sync[2] != state_q.clk_lvl);

		// Causes; the pin is only ever read, internal causes leave it alone
		pin_hit = !state_q.ext_lvl;
		cmp_hit = state_q.cmp_en && !state_q.cmp_lvl;
		lost_fire = state_q.lost_en && (state_q.lost_cnt >= 32'(LOST_CLOCK_CYCLES));
		wdog_fire = state_q.wdog_en
			&& (state_q.wdog_cnt == wdog_limit(state_q.wdog_sel));

		// One-shot retriggered by clock activity, idle while disabled
		if (!state_q.lost_en)
		begin
			state_d.lost_cnt = 32'h0;
		end
		else if (clk_edge)
		begin
			state_d.lost_cnt = 32'h0;
		end
		else if (state_q.lost_cnt < 32'(LOST_CLOCK_CYCLES))
		begin
			state_d.lost_cnt = state_q.lost_cnt + 32'h1;
		end

		// Watchdog counts every cycle of i_clock while enabled
		if (state_q.wdog_en)
		begin
			state_d.wdog_cnt = state_q.wdog_cnt + `RSC_WDOG_W'(1);
		end

		// Capture write address and data in either order
		if (i_awvalid && !state_q.aw_have)
		begin
			state_d.aw_have = 1'b1;
			state_d.aw_addr = i_awaddr;
		end
		if (i_wvalid && !state_q.w_have)
		begin
			state_d.w_have = 1'b1;
			state_d.w_data = i_wdata[7:0];
			state_d.w_strb0 = i_wstrb[0];
		end

		// Retire write answer
		if (state_q.bvalid && i_bready)
		begin
			state_d.bvalid = 1'b0;
		end

		// Execute write once both halves are in and the answer slot is free
		if (state_q.aw_have && state_q.w_have && !state_q.bvalid)
		begin
			state_d.aw_have = 1'b0;
			state_d.w_have = 1'b0;
			state_d.bvalid = 1'b1;
			state_d.bresp = mapped(state_q.aw_addr) ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
			// Writes during reset are dropped; software is not running then
			if (state_q.w_strb0 && (state_q.state == rsc_pkg::ST_RUN))
			begin
				case (state_q.aw_addr)
					`RSC_ADDR_CAUSE:
					begin
						// Flags are read-only; only the arm bit is writable
						state_d.cmp_en = state_q.w_data[`RSC_BIT_CMP_EN];
					end
					`RSC_ADDR_OSC:
					begin
						state_d.lost_en = state_q.w_data[`RSC_BIT_LOST_EN];
					end
					`RSC_ADDR_WDOG:
					begin
						case (state_q.w_data)
							`RSC_WDOG_KICK:
							begin
								state_d.wdog_en = 1'b1;
								state_d.wdog_cnt = '0;
							end
							`RSC_WDOG_DISABLE:
							begin
								// Lock makes disable a no-op
								if (!state_q.wdog_lock)
								begin
									state_d.wdog_en = 1'b0;
								end
							end
							`RSC_WDOG_LOCK:
							begin
								state_d.wdog_lock = 1'b1;
								state_d.wdog_en = 1'b1;
							end
							default:
							begin
								// Non-command bytes with bit 7 clear set the interval
								if (!state_q.w_data[`RSC_BIT_WDOG_CMD])
								begin
									state_d.wdog_sel = state_q.w_data[2:0];
								end
							end
						endcase
					end
					default:
					begin
						state_d.bresp = `RSC_RESP_SLVERR;
					end
				endcase
			end
		end

		// Read path: one read outstanding, answered the cycle after
		if (state_q.rvalid && i_rready)
		begin
			state_d.rvalid = 1'b0;
		end
		if (i_arvalid && !state_q.rvalid)
		begin
			state_d.rvalid = 1'b1;
			state_d.rdata = read_reg(state_q, i_araddr);
			state_d.rresp = mapped(i_araddr) ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
		end

		// Reset sequencer
		case (state_q.state)
			rsc_pkg::ST_RUN:
			begin
				// Priority: pin, lost clock, comparator, watchdog
				if (pin_hit || lost_fire || cmp_hit || wdog_fire)
				begin
					state_d.state = rsc_pkg::ST_HOLD;
					state_d.hold_cnt = `RSC_HOLD_CYCLES;
					if (pin_hit)
					begin
						state_d.cause = rsc_pkg::CAUSE_PIN;
					end
					else if (lost_fire)
					begin
						state_d.cause = rsc_pkg::CAUSE_LOST;
					end
					else if (cmp_hit)
					begin
						state_d.cause = rsc_pkg::CAUSE_CMP;
					end
					else
					begin
						state_d.cause = rsc_pkg::CAUSE_WDOG;
					end
				end
			end
			rsc_pkg::ST_HOLD:
			begin
				// Pin or armed comparator still active restarts the release count
				if (pin_hit || cmp_hit)
				begin
					state_d.hold_cnt = `RSC_HOLD_CYCLES;
					if (pin_hit)
					begin
						state_d.cause = rsc_pkg::CAUSE_PIN;
					end
				end
				else if (state_q.hold_cnt == 4'h1)
				begin
					// Release: flags name only this reset's cause
					state_d.state = rsc_pkg::ST_RUN;
					state_d.pin_flag = (state_q.cause == rsc_pkg::CAUSE_PIN);
					state_d.lost_flag = (state_q.cause == rsc_pkg::CAUSE_LOST);
					state_d.wdog_flag = (state_q.cause == rsc_pkg::CAUSE_WDOG);
					state_d.cmp_en = (state_q.cause == rsc_pkg::CAUSE_CMP);
				end
				else
				begin
					state_d.hold_cnt = state_q.hold_cnt - 4'h1;
				end
			end
			default:
			begin
				state_d.state = rsc_pkg::ST_HOLD;
				state_d.hold_cnt = `RSC_HOLD_CYCLES;
			end
		endcase

		// Any cycle in reset: watchdog back to enabled, unlocked, longest
		if (state_d.state == rsc_pkg::ST_HOLD)
		begin
			state_d.wdog_en = 1'b1;
			state_d.wdog_lock = 1'b0;
			state_d.wdog_sel = `RSC_WDOG_SEL_MAX;
			state_d.wdog_cnt = '0;
			state_d.lost_en = 1'b0;
			state_d.lost_cnt = 32'h0;
		end
	end

	// ****************************************
	// State register
	// ****************************************

	// Synchronous power-on reset loads constants only
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			state_q <= RESET_STATE;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************

	// Core reset is a decode of the state flop
	assign o_sys_reset = (state_q.state == rsc_pkg::ST_HOLD);
	assign o_awready = !state_q.aw_have;
	assign o_wready = !state_q.w_have;
	assign o_bvalid = state_q.bvalid;
	assign o_bresp = state_q.bresp;
	assign o_arready = !state_q.rvalid;
	assign o_rvalid = state_q.rvalid;
	assign o_rdata = {24'h000000, state_q.rdata};
	assign o_rresp = state_q.rresp;

endmodule // rsc_reset_source

`default_nettype wire

// File: sim/rsc_far_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Pin circuitry and comparator
// ****************************************
module rsc_far_model (
	// Clock
	input wire logic i_clock,
	// Scenario controls
	input wire logic i_pin_low,
	input wire logic i_cmp_low,
	input wire logic i_clk_stop,
	// Far side pins
	output logic o_ext_reset_n,
	output logic o_comparator_out,
	output logic o_system_clock
);
	// Divider for the watched system clock
	logic [1:0] div_q = 2'h0;
	// Pull-up keeps pin high when released
	assign o_ext_reset_n = !i_pin_low;
	// Enabled early, so no start-up chatter
	assign o_comparator_out = !i_cmp_low;
	// Clock freezes when stopped
	always_ff @(posedge i_clock)
	begin
		if (!i_clk_stop)
			div_q <= div_q + 2'h1;
	end
	assign o_system_clock = div_q[1];
endmodule // rsc_far_model
`default_nettype wire

// File: sim/rsc_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Reset sequencer port checks
// ****************************************
module rsc_monitor (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// Reset pins
	input wire logic i_ext_reset_n,
	input wire logic o_sys_reset,
	// Bus answers
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic i_bready,
	input wire logic o_bvalid,
	input wire logic [1:0] o_bresp,
	input wire logic i_rready,
	input wire logic o_rvalid,
	input wire logic [31:0] o_rdata
);
	// Run length of core reset, saturating
	logic [4:0] hi_q;
	logic [4:0] hi_d;
	always_comb
	begin
		hi_d = hi_q;
		if (!o_sys_reset)
			hi_d = 5'h00;
		else if (hi_q != 5'h1F)
			hi_d = hi_q + 5'h01;
	end
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			hi_q <= 5'h00;
		else
			hi_q <= hi_d;
	end
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	// Pin held long enough to pass the synchroniser
	sequence s_pin_held; !i_ext_reset_n [*8]; endsequence
	// Twelve cycles of core reset
	sequence s_hold12; o_sys_reset [*8] ##1 o_sys_reset [*4]; endsequence
	property p_pin_enter; s_pin_held |-> o_sys_reset; endproperty
	a_pin_enter: assert property (p_pin_enter)
		else $error("core not in reset while pin low");
	property p_pin_hold; $rose(i_ext_reset_n) |-> s_hold12; endproperty
	a_pin_hold: assert property (p_pin_hold)
		else $error("core left reset early");
	property p_pin_exit; $rose(i_ext_reset_n) |-> ##[12:24] !o_sys_reset; endproperty
	a_pin_exit: assert property (p_pin_exit)
		else $error("core stuck in reset");
	property p_hold_len; $fell(o_sys_reset) |-> hi_q >= 5'h0C; endproperty
	a_hold_len: assert property (p_hold_len)
		else $error("reset pulse shorter than twelve");
	property p_por_hold; $fell(i_rst) |-> s_hold12; endproperty
	a_por_hold: assert property (p_por_hold)
		else $error("power-on hold too short");
	property p_b_stand; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
	a_b_stand: assert property (p_b_stand)
		else $error("write answer dropped");
	property p_r_stand; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
	a_r_stand: assert property (p_r_stand)
		else $error("read answer dropped");
	property p_r_answer; i_arvalid && o_arready |=> o_rvalid; endproperty
	a_r_answer: assert property (p_r_answer)
		else $error("read answer late");
	property p_r_top; o_rvalid |-> o_rdata[31:8] == 24'h000000 && !o_arready; endproperty
	a_r_top: assert property (p_r_top)
		else $error("read upper bits or ready wrong");
endmodule // rsc_monitor
bind rsc_reset_source rsc_monitor u_mon (.i_clock(i_clock), .i_rst(i_rst),
	.i_ext_reset_n(i_ext_reset_n), .o_sys_reset(o_sys_reset), .i_arvalid(i_arvalid),
	.o_arready(o_arready), .i_bready(i_bready), .o_bvalid(o_bvalid), .o_bresp(o_bresp),
	.i_rready(i_rready), .o_rvalid(o_rvalid), .o_rdata(o_rdata));
`default_nettype wire

// File: sim/test_rsc_reset_source.sv
`timescale 1ns/100ps
`default_nettype none
module test_rsc_reset_source;
	// Clock, reset and far side controls
	logic i_clock = 1'b0, i_rst = 1'b1, pl = 1'b0, cl = 1'b0, cs = 1'b0;
	logic ext_n, cmp, sclk, srst;
	// Bus signals
	logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic awr, wrd, bv, arr, rv;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rdat, v;
	logic [1:0] bresp, rresp, r;
	int error_cnt = 0, tests_run = 0, cyc = 0, n;
	initial
	begin
		forever #10 i_clock = ~i_clock;
	end
	rsc_far_model far (.i_clock(i_clock), .i_pin_low(pl), .i_cmp_low(cl), .i_clk_stop(cs),
		.o_ext_reset_n(ext_n), .o_comparator_out(cmp), .o_system_clock(sclk));
	rsc_reset_source #(.LOST_CLOCK_CYCLES(50)) dut (.i_clock(i_clock), .i_rst(i_rst),
		.i_ext_reset_n(ext_n), .i_system_clock(sclk), .i_comparator_out(cmp),
		.o_sys_reset(srst), .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa),
		.i_wvalid(wv), .o_wready(wrd), .i_wdata(wd), .i_wstrb(4'hF), .o_bvalid(bv),
		.i_bready(br), .o_bresp(bresp), .i_arvalid(arv), .o_arready(arr),
		.i_araddr(ara), .o_rvalid(rv), .i_rready(rr), .o_rdata(rdat), .o_rresp(rresp));
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Hang guard
	always @(posedge i_clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 90000)
		begin
			error_cnt++;
			test_done;
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Bus write, answer taken one cycle after valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
		@(posedge i_clock);
		awa <= a;
		wd <= {24'h000000, d};
		awv <= 1'b1;
		wv <= 1'b1;
		do
		begin
			@(posedge i_clock);
			if (awr)
				awv <= 1'b0;
			if (wrd)
				wv <= 1'b0;
		end
		while (bv !== 1'b1);
		br <= 1'b1;
		@(posedge i_clock);
		r = bresp;
		br <= 1'b0;
		chk({30'h0, r}, {30'h0, e});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge i_clock);
		ara <= a;
		arv <= 1'b1;
		do
		begin
			@(posedge i_clock);
			if (arr)
				arv <= 1'b0;
		end
		while (rv !== 1'b1);
		rr <= 1'b1;
		@(posedge i_clock);
		v = rdat;
		r = rresp;
		rr <= 1'b0;
		chk(v, e);
		chk({30'h0, r}, {30'h0, er});
	endtask
	// Cycles until core reset reaches a level
	task automatic wl(input logic lv, output int c);
		c = 0;
		do
		begin
			@(posedge i_clock);
			c++;
		end
		while (srst !== lv);
	endtask
	initial
	begin
		repeat (8) @(posedge i_clock);
		i_rst <= 1'b0;
		wl(1'b0, n);
		rd(8'h00, 32'h00, 2'h0);
		rd(8'h08, 32'h17, 2'h0);
		rd(8'h0C, 32'h00, 2'h2);
		wr(8'h0C, 8'h01, 2'h2);
		$display("test power_on done");
		pl <= 1'b1;
		repeat (10) @(posedge i_clock);
		chk(32'(srst), 32'h1);
		pl <= 1'b0;
		wl(1'b0, n);
		chk(32'(n >= 12), 32'h1);
		rd(8'h00, 32'h01, 2'h0);
		$display("test pin done");
		// Detector off: a frozen clock is ignored
		cs <= 1'b1;
		repeat (200) @(posedge i_clock);
		chk(32'(srst), 32'h0);
		cs <= 1'b0;
		wr(8'h04, 8'h80, 2'h0);
		rd(8'h04, 32'h80, 2'h0);
		repeat (200) @(posedge i_clock);
		chk(32'(srst), 32'h0);
		cs <= 1'b1;
		wl(1'b1, n);
		chk(32'(n > 50 && n <= 60), 32'h1);
		cs <= 1'b0;
		wl(1'b0, n);
		rd(8'h00, 32'h04, 2'h0);
		rd(8'h04, 32'h00, 2'h0);
		$display("test lost_clock done");
		cl <= 1'b1;
		repeat (20) @(posedge i_clock);
		chk(32'(srst), 32'h0);
		cl <= 1'b0;
		// Let the filtered comparator settle high before arming
		repeat (8) @(posedge i_clock);
		wr(8'h00, 8'h20, 2'h0);
		rd(8'h00, 32'h24, 2'h0);
		cl <= 1'b1;
		wl(1'b1, n);
		chk(32'(n <= 8), 32'h1);
		cl <= 1'b0;
		wl(1'b0, n);
		rd(8'h00, 32'h20, 2'h0);
		$display("test comparator done");
		wr(8'h08, 8'hDE, 2'h0);
		rd(8'h08, 32'h07, 2'h0);
		wr(8'h08, 8'hFF, 2'h0);
		wr(8'h08, 8'hDE, 2'h0);
		rd(8'h08, 32'h37, 2'h0);
		// Shortest interval; kicks spaced inside it keep the core running
		wr(8'h08, 8'h00, 2'h0);
		repeat (3)
		begin
			repeat (12000) @(posedge i_clock);
			wr(8'h08, 8'hA5, 2'h0);
		end
		// Without the restarts the count would have passed the limit
		chk(32'(srst), 32'h0);
		// Last kick to core reset: about 2^14 cycles at interval 0
		wl(1'b1, n);
		chk(32'(n > 16373 && n < 16393), 32'h1);
		wl(1'b0, n);
		rd(8'h00, 32'h08, 2'h0);
		rd(8'h08, 32'h17, 2'h0);
		$display("test watchdog done");
		test_done;
	end
endmodule // test_rsc_reset_source
`default_nettype wire
